// file: design/urmd_pkg.sv
// urmd_pkg: constants, field positions, reset values and carrier structs
// for the uart register map decoder.
// assumes a byte-wide register port from the serial slave front end.
//
// Notes on behaviour
// R1 - offset 0 holds data when divisor access off
// R2 - divisor bytes need access bit, not 0xBF
// R3 - fractional divisor also needs enhanced unlock bit
// R4 - offset 2 reads status, writes fifo control
// R5 - enhanced function register only under 0xBF
// R6 - 0xBF maps resume/halt characters at 4..7
// R7 - enhanced bits writable only when unlocked
// R8 - interrupt enable bit meanings, enhanced upper nibble
// R9 - fifo control bit meanings on write
// R10 - line control field layout
// R11 - modem control drives lines and options
// R12 - line status read only, error and empty
// R13 - modem status changes and live levels
// R14 - offset 7 scratch byte, no side effects
// R15 - offset 6 flow levels when selected
// R16 - offset 7 trigger levels when selected
// R17 - offsets 8,9 report fifo fill counts
// R18 - gpio registers at 0xA..0xE, 0xD reserved
// R19 - offset 0xF extra features control
// R20 - word length sets compare width
// R21 - halt at halt level, resume at resume
// R22 - read-only and reserved writes ignored
// R23 - data accesses pop and push fifos
package urmd_pkg;

  // register offsets
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_IER = 4'h1;
  localparam logic [3:0] OFS_ISR = 4'h2;
  localparam logic [3:0] OFS_LCR = 4'h3;
  localparam logic [3:0] OFS_MCR = 4'h4;
  localparam logic [3:0] OFS_LSR = 4'h5;
  localparam logic [3:0] OFS_MSR = 4'h6;
  localparam logic [3:0] OFS_SPR = 4'h7;
  localparam logic [3:0] OFS_TXLV = 4'h8;
  localparam logic [3:0] OFS_RXLV = 4'h9;
  localparam logic [3:0] OFS_GDIR = 4'hA;
  localparam logic [3:0] OFS_GST = 4'hB;
  localparam logic [3:0] OFS_GIE = 4'hC;
  localparam logic [3:0] OFS_RSVD = 4'hD;
  localparam logic [3:0] OFS_GCTL = 4'hE;
  localparam logic [3:0] OFS_XFC = 4'hF;

  // line control value that opens the enhanced bank
  localparam logic [7:0] LC_ENH_KEY = 8'hBF;
  // field positions
  localparam int LC_DIV_BIT = 7;
  localparam int EF_UNLOCK_BIT = 4;
  localparam int MC_LEVELS_BIT = 2;
  localparam int FC_ENABLE_BIT = 0;
  localparam int FC_RXRST_BIT = 1;
  localparam int FC_TXRST_BIT = 2;
  // enhanced bits per register, gated by the unlock bit
  localparam logic [7:0] IE_ENH_MASK = 8'hF0;
  localparam logic [7:0] FC_ENH_MASK = 8'h30;
  localparam logic [7:0] MC_ENH_MASK = 8'hE0;
  localparam logic [5:0] IS_ENH_MASK = 6'h30;
  // reset value of every stored byte
  localparam logic [7:0] RST_BYTE = 8'h00;
  // flow levels count in steps of four bytes
  localparam int FLOW_LEVEL_SHIFT = 2;
  // full-width character compare mask
  localparam logic [7:0] CHAR_MASK_FULL = 8'hFF;

  // one register request from the slave front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } urmd_req_s;

  // receive status levels reported by the serial engine
  typedef struct packed {
    logic global_err;
    logic shift_empty;
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
  } urmd_rx_stat_s;

  // configuration handed to the uart core
  typedef struct packed {
    logic [15:0] divisor;
    logic [3:0] frac;
    logic mode_8x;
    logic mode_4x;
    logic [7:0] line_control;
    logic [7:0] char_mask;
    logic [7:0] int_enable;
    logic [7:0] fifo_control;
    logic [7:0] enhanced;
    logic [7:0] modem_control;
    logic [7:0] trigger_levels;
    logic [7:0] resume_one;
    logic [7:0] resume_two;
    logic [7:0] halt_one;
    logic [7:0] halt_two;
    logic [7:0] gpio_dir;
    logic [7:0] gpio_state;
    logic [7:0] gpio_irq_en;
    logic [7:0] gpio_ctl;
    logic [7:0] extra_ctl;
  } urmd_cfg_s;

endpackage

// file: design/urmd_decoder.sv
// urmd_decoder: register map, address decode and fill accounting of a
// serial uart with fifos.
// assumes one request per cycle from the slave front end, and a uart
// core that supplies receive data, status levels and fifo events.
`timescale 1ns/1ns
`default_nettype none

module urmd_decoder #(
  parameter int FIFO_DEPTH = 64, // bytes per fifo
  parameter int LVL_W = 7 // width of a fill count
) (
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire urmd_pkg::urmd_req_s req,
  output logic [7:0] rd_data,
  // uart core side
  input wire logic [7:0] rx_data,
  input wire logic rx_push,
  input wire logic tx_pop,
  input wire urmd_pkg::urmd_rx_stat_s rx_stat,
  input wire logic [5:0] int_source,
  input wire logic [3:0] modem_in,
  output logic tx_push,
  output logic [7:0] tx_data,
  output logic rx_pop,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset,
  output logic send_halt,
  output logic send_resume,
  output urmd_pkg::urmd_cfg_s cfg
);

  // stored registers
  logic [7:0] divisor_low;
  logic [7:0] divisor_high;
  logic [7:0] divisor_fraction;
  logic [7:0] interrupt_enable;
  logic [7:0] fifo_control;
  logic [7:0] enhanced_function;
  logic [7:0] line_control;
  logic [7:0] modem_control;
  logic [7:0] scratch;
  logic [7:0] flow_levels;
  logic [7:0] fifo_trigger_levels;
  logic [7:0] resume_char_one;
  logic [7:0] resume_char_two;
  logic [7:0] halt_char_one;
  logic [7:0] halt_char_two;
  logic [7:0] gpio_direction;
  logic [7:0] gpio_state;
  logic [7:0] gpio_irq_enable;
  logic [7:0] gpio_control;
  logic [7:0] extra_features_control;
  // fifo fill counts and modem change tracking
  logic [LVL_W-1:0] tx_count;
  logic [LVL_W-1:0] rx_count;
  logic [3:0] modem_prev;
  logic [3:0] modem_delta;
  logic flow_halted;

  // bank decode: the key value wins over the plain access bit
  wire bank_enh = (line_control == urmd_pkg::LC_ENH_KEY);
  wire bank_div = line_control[urmd_pkg::LC_DIV_BIT] & ~bank_enh; // see R2
  wire bank_std = ~line_control[urmd_pkg::LC_DIV_BIT]; // see R1
  wire unlocked = enhanced_function[urmd_pkg::EF_UNLOCK_BIT]; // see R7
  // flow levels and trigger levels replace status and scratch
  wire levels_on = modem_control[urmd_pkg::MC_LEVELS_BIT] & unlocked;

  // per-register select wires
  wire a_data = (req.addr == urmd_pkg::OFS_DATA);
  wire a_one = (req.addr == urmd_pkg::OFS_IER);
  wire a_two = (req.addr == urmd_pkg::OFS_ISR);
  wire a_four = (req.addr == urmd_pkg::OFS_MCR);
  wire a_five = (req.addr == urmd_pkg::OFS_LSR);
  wire a_six = (req.addr == urmd_pkg::OFS_MSR);
  wire a_seven = (req.addr == urmd_pkg::OFS_SPR);
  wire sel_holding = a_data & bank_std; // see R1
  wire sel_dll = a_data & bank_div; // see R2
  wire sel_dlm = a_one & bank_div; // see R2
  wire sel_dld = a_two & bank_div & unlocked; // see R3
  wire sel_ier = a_one & bank_std; // see R8
  wire sel_isr_fcr = a_two & bank_std; // see R4
  wire sel_efr = a_two & bank_enh; // see R5
  wire sel_mcr = a_four & ~bank_enh; // see R11
  wire sel_lsr = a_five & ~bank_enh; // see R12
  wire sel_msr = a_six & ~bank_enh & ~levels_on; // see R13
  wire sel_tcr = a_six & ~bank_enh & levels_on; // see R15
  wire sel_spr = a_seven & ~bank_enh & ~levels_on; // see R14
  wire sel_tlr = a_seven & ~bank_enh & levels_on; // see R16
  wire sel_xon1 = a_four & bank_enh; // see R6
  wire sel_xon2 = a_five & bank_enh; // see R6
  wire sel_xoff1 = a_six & bank_enh; // see R6
  wire sel_xoff2 = a_seven & bank_enh; // see R6

  // write strobes, one per writable register
  wire w_dll = req.wr & sel_dll;
  wire w_dlm = req.wr & sel_dlm;
  wire w_dld = req.wr & sel_dld;
  wire w_ier = req.wr & sel_ier;
  wire w_fcr = req.wr & sel_isr_fcr;
  wire w_efr = req.wr & sel_efr;
  wire w_lcr = req.wr & (req.addr == urmd_pkg::OFS_LCR);
  wire w_mcr = req.wr & sel_mcr;
  wire w_spr = req.wr & sel_spr;
  wire w_tcr = req.wr & sel_tcr;
  wire w_tlr = req.wr & sel_tlr;
  wire w_xon1 = req.wr & sel_xon1;
  wire w_xon2 = req.wr & sel_xon2;
  wire w_xoff1 = req.wr & sel_xoff1;
  wire w_xoff2 = req.wr & sel_xoff2;
  wire w_gdir = req.wr & (req.addr == urmd_pkg::OFS_GDIR); // see R18
  wire w_gst = req.wr & (req.addr == urmd_pkg::OFS_GST); // see R18
  wire w_gie = req.wr & (req.addr == urmd_pkg::OFS_GIE); // see R18
  wire w_gctl = req.wr & (req.addr == urmd_pkg::OFS_GCTL); // see R18
  wire w_xfc = req.wr & (req.addr == urmd_pkg::OFS_XFC); // see R19

  // enhanced bits keep their old value unless the unlock bit is set
  wire [7:0] ier_keep = unlocked ? 8'h00 : urmd_pkg::IE_ENH_MASK; // see R7
  wire [7:0] fcr_keep = unlocked ? 8'h00 : urmd_pkg::FC_ENH_MASK; // see R7
  wire [7:0] mcr_keep = unlocked ? 8'h00 : urmd_pkg::MC_ENH_MASK; // see R7
  wire [7:0] next_ier = (req.wdata & ~ier_keep) | (interrupt_enable & ier_keep);
  wire [7:0] next_fcr = (req.wdata & ~fcr_keep) | (fifo_control & fcr_keep);
  wire [7:0] next_mcr = (req.wdata & ~mcr_keep) | (modem_control & mcr_keep);
  // enhanced bits read as zero while locked
  wire [7:0] ier_view = unlocked ? interrupt_enable
                                 : (interrupt_enable & ~urmd_pkg::IE_ENH_MASK);
  wire [7:0] fcr_view = unlocked ? fifo_control
                                 : (fifo_control & ~urmd_pkg::FC_ENH_MASK);
  wire [7:0] mcr_view = unlocked ? modem_control
                                 : (modem_control & ~urmd_pkg::MC_ENH_MASK);
  wire [5:0] isr_src = unlocked ? int_source
                                : (int_source & ~urmd_pkg::IS_ENH_MASK);

  // fifo control reset bits act as one-cycle pulses, never stored
  wire rx_rst = w_fcr & req.wdata[urmd_pkg::FC_RXRST_BIT]; // see R9
  wire tx_rst = w_fcr & req.wdata[urmd_pkg::FC_TXRST_BIT]; // see R9
  wire fifo_on = fifo_control[urmd_pkg::FC_ENABLE_BIT];

  // data accesses move the fifos; a full or empty fifo refuses them
  wire tx_full = (tx_count == LVL_W'(FIFO_DEPTH));
  wire rx_full = (rx_count == LVL_W'(FIFO_DEPTH));
  wire rx_empty = (rx_count == '0);
  wire do_push = req.wr & sel_holding & ~tx_full; // see R23
  wire do_pop = req.rd & sel_holding & ~rx_empty; // see R23
  wire do_tx_pop = tx_pop & (tx_count != '0);
  wire do_rx_push = rx_push & ~rx_full;

  // status bytes built from core levels and own counts
  wire [7:0] isr_byte = {{2{fifo_on}}, isr_src}; // see R4
  wire [7:0] lsr_byte = {rx_stat.global_err,
                         (tx_count == '0) & rx_stat.shift_empty,
                         (tx_count == '0),
                         rx_stat.brk, rx_stat.framing, rx_stat.parity,
                         rx_stat.overrun, ~rx_empty}; // see R12
  wire [7:0] msr_byte = {modem_in, modem_delta}; // see R13
  wire [7:0] tx_fill_level_byte = 8'(tx_count) & 8'h7F; // see R17
  wire [7:0] rx_fill_level_byte = 8'(rx_count) & 8'h7F; // see R17

  // modem change flags: new edges win over the clearing read
  wire msr_read = req.rd & sel_msr;
  wire [3:0] modem_change = modem_in ^ modem_prev;
  wire [3:0] next_delta = (msr_read ? 4'h0 : modem_delta) | modem_change;

  // flow thresholds scaled to bytes
  wire [LVL_W-1:0] halt_lvl = LVL_W'({flow_levels[3:0], 2'b00}
                                     >> (2 - urmd_pkg::FLOW_LEVEL_SHIFT));
  wire [LVL_W-1:0] resume_lvl = LVL_W'({flow_levels[7:4], 2'b00}
                                       >> (2 - urmd_pkg::FLOW_LEVEL_SHIFT));
  wire sw_flow_on = (enhanced_function[3:0] != 4'h0);
  wire hit_halt = sw_flow_on & ~flow_halted & (rx_count >= halt_lvl); // see R21
  wire hit_resume = flow_halted & (rx_count <= resume_lvl); // see R21

  // read mux; unmapped and reserved slots answer zero
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00; // see R22
    case (req.addr)
      urmd_pkg::OFS_DATA: begin
        if (sel_holding) next_rdata = rx_data; // see R1
        else if (sel_dll) next_rdata = divisor_low;
      end
      urmd_pkg::OFS_IER: begin
        if (sel_dlm) next_rdata = divisor_high;
        else if (sel_ier) next_rdata = ier_view; // see R8
      end
      urmd_pkg::OFS_ISR: begin
        if (sel_efr) next_rdata = enhanced_function; // see R5
        else if (sel_dld) next_rdata = divisor_fraction; // see R3
        else if (sel_isr_fcr) next_rdata = isr_byte; // see R4
      end
      urmd_pkg::OFS_LCR: next_rdata = line_control; // see R10
      urmd_pkg::OFS_MCR: begin
        next_rdata = sel_xon1 ? resume_char_one : mcr_view; // see R11
      end
      urmd_pkg::OFS_LSR: begin
        next_rdata = sel_xon2 ? resume_char_two : lsr_byte;
      end
      urmd_pkg::OFS_MSR: begin
        if (sel_xoff1) next_rdata = halt_char_one;
        else if (sel_tcr) next_rdata = flow_levels; // see R15
        else next_rdata = msr_byte;
      end
      urmd_pkg::OFS_SPR: begin
        if (sel_xoff2) next_rdata = halt_char_two;
        else if (sel_tlr) next_rdata = fifo_trigger_levels; // see R16
        else next_rdata = scratch; // see R14
      end
      urmd_pkg::OFS_TXLV: next_rdata = tx_fill_level_byte;
      urmd_pkg::OFS_RXLV: next_rdata = rx_fill_level_byte;
      urmd_pkg::OFS_GDIR: next_rdata = gpio_direction;
      urmd_pkg::OFS_GST: next_rdata = gpio_state;
      urmd_pkg::OFS_GIE: next_rdata = gpio_irq_enable;
      urmd_pkg::OFS_GCTL: next_rdata = gpio_control;
      urmd_pkg::OFS_XFC: next_rdata = extra_features_control;
      default: next_rdata = 8'h00; // reserved slot, see R22
    endcase
  end

  // read data is registered; it is held until the next read
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= urmd_pkg::RST_BYTE;
    end else if (req.rd) begin
      rd_data <= next_rdata;
    end
  end

  // divisor bank and line control
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divisor_low <= urmd_pkg::RST_BYTE;
      divisor_high <= urmd_pkg::RST_BYTE;
      divisor_fraction <= urmd_pkg::RST_BYTE;
      line_control <= urmd_pkg::RST_BYTE;
    end else begin
      if (w_dll) divisor_low <= req.wdata; // see R2
      if (w_dlm) divisor_high <= req.wdata; // see R2
      if (w_dld) divisor_fraction <= req.wdata; // see R3
      if (w_lcr) line_control <= req.wdata; // see R10
    end
  end

  // standard control registers with guarded enhanced bits
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      interrupt_enable <= urmd_pkg::RST_BYTE;
      fifo_control <= urmd_pkg::RST_BYTE;
      modem_control <= urmd_pkg::RST_BYTE;
      scratch <= urmd_pkg::RST_BYTE;
    end else begin
      if (w_ier) interrupt_enable <= next_ier; // see R7
      // the reset bits are not kept, they only pulse
      if (w_fcr) fifo_control <= next_fcr & 8'hF9; // see R9
      if (w_mcr) modem_control <= next_mcr; // see R7
      if (w_spr) scratch <= req.wdata; // see R14
    end
  end

  // enhanced bank: function, characters; plus unlocked flow and trigger levels
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      enhanced_function <= urmd_pkg::RST_BYTE;
      resume_char_one <= urmd_pkg::RST_BYTE;
      resume_char_two <= urmd_pkg::RST_BYTE;
      halt_char_one <= urmd_pkg::RST_BYTE;
      halt_char_two <= urmd_pkg::RST_BYTE;
      flow_levels <= urmd_pkg::RST_BYTE;
      fifo_trigger_levels <= urmd_pkg::RST_BYTE;
    end else begin
      if (w_efr) enhanced_function <= req.wdata; // see R5
      if (w_xon1) resume_char_one <= req.wdata; // see R6
      if (w_xon2) resume_char_two <= req.wdata; // see R6
      if (w_xoff1) halt_char_one <= req.wdata; // see R6
      if (w_xoff2) halt_char_two <= req.wdata; // see R6
      if (w_tcr) flow_levels <= req.wdata; // see R15
      if (w_tlr) fifo_trigger_levels <= req.wdata; // see R16
    end
  end

  // gpio and extra feature storage; layouts belong to the core
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_direction <= urmd_pkg::RST_BYTE;
      gpio_state <= urmd_pkg::RST_BYTE;
      gpio_irq_enable <= urmd_pkg::RST_BYTE;
      gpio_control <= urmd_pkg::RST_BYTE;
      extra_features_control <= urmd_pkg::RST_BYTE;
    end else begin
      if (w_gdir) gpio_direction <= req.wdata;
      if (w_gst) gpio_state <= req.wdata;
      if (w_gie) gpio_irq_enable <= req.wdata;
      if (w_gctl) gpio_control <= req.wdata;
      if (w_xfc) extra_features_control <= req.wdata; // see R19
    end
  end

  // transmit fill count: a fifo reset beats any event that cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_count <= '0;
    end else if (tx_rst) begin
      tx_count <= '0;
    end else begin
      tx_count <= tx_count + LVL_W'(do_push) - LVL_W'(do_tx_pop); // see R23
    end
  end

  // receive fill count
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_count <= '0;
    end else if (rx_rst) begin
      rx_count <= '0;
    end else begin
      rx_count <= rx_count + LVL_W'(do_rx_push) - LVL_W'(do_pop); // see R23
    end
  end

  // modem change detection; the first sample after reset is not a change
  logic modem_primed;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      modem_prev <= 4'h0;
      modem_delta <= 4'h0;
      modem_primed <= 1'b0;
    end else begin
      modem_prev <= modem_in;
      modem_primed <= 1'b1;
      if (modem_primed) modem_delta <= next_delta; // see R13
    end
  end

  // software flow: halt once at the halt level, resume once at or below the resume level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      flow_halted <= 1'b0;
      send_halt <= 1'b0;
      send_resume <= 1'b0;
    end else begin
      send_halt <= hit_halt; // see R21
      send_resume <= hit_resume; // see R21
      if (hit_halt) flow_halted <= 1'b1;
      else if (hit_resume) flow_halted <= 1'b0;
    end
  end

  // strobes toward the core are registered with their data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_push <= 1'b0;
      tx_data <= urmd_pkg::RST_BYTE;
      rx_pop <= 1'b0;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
    end else begin
      tx_push <= do_push; // see R1
      if (do_push) tx_data <= req.wdata;
      rx_pop <= do_pop; // see R23
      rx_fifo_reset <= rx_rst; // see R9
      tx_fifo_reset <= tx_rst; // see R9
    end
  end

  // compare width follows the word length field
  wire [7:0] char_mask = urmd_pkg::CHAR_MASK_FULL
                         >> (2'd3 - line_control[1:0]); // see R20

  // configuration view for the core, from the registers; enhanced bits read as zero while locked
  assign cfg.divisor = {divisor_high, divisor_low};
  assign cfg.frac = divisor_fraction[3:0]; // see R3
  assign cfg.mode_8x = divisor_fraction[4];
  assign cfg.mode_4x = divisor_fraction[5];
  assign cfg.line_control = line_control;
  assign cfg.char_mask = char_mask;
  assign cfg.int_enable = ier_view;
  assign cfg.fifo_control = fcr_view;
  assign cfg.enhanced = enhanced_function;
  assign cfg.modem_control = mcr_view;
  assign cfg.trigger_levels = fifo_trigger_levels;
  assign cfg.resume_one = resume_char_one;
  assign cfg.resume_two = resume_char_two;
  assign cfg.halt_one = halt_char_one;
  assign cfg.halt_two = halt_char_two;
  assign cfg.gpio_dir = gpio_direction;
  assign cfg.gpio_state = gpio_state;
  assign cfg.gpio_irq_en = gpio_irq_enable;
  assign cfg.gpio_ctl = gpio_control;
  assign cfg.extra_ctl = extra_features_control;

endmodule // urmd_decoder

`default_nettype wire

// file: tb/urmd_decoder_asserts.sv
// urmd_decoder_asserts: port-level checks of the register decoder.
// assumes it is bound to every urmd_decoder instance.
`timescale 1ns/1ns
`default_nettype none
module urmd_decoder_asserts #(
  parameter int FIFO_DEPTH = 64
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire urmd_pkg::urmd_req_s req,
  input wire logic [7:0] rd_data,
  input wire urmd_pkg::urmd_rx_stat_s rx_stat,
  input wire logic tx_push,
  input wire logic [7:0] tx_data,
  input wire logic rx_pop,
  input wire logic rx_fifo_reset,
  input wire logic tx_fifo_reset,
  input wire urmd_pkg::urmd_cfg_s cfg
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_push;
    tx_push |-> $past(req.wr && req.addr == 4'h0 &&
      !cfg.line_control[7]) && tx_data == $past(req.wdata);
  endproperty
  a_push: assert property (p_push)
    else $error("push without data write");
  property p_pop;
    rx_pop |-> $past(req.rd && req.addr == 4'h0 && !cfg.line_control[7]);
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop without data read");
  property p_rxrst;
    rx_fifo_reset |-> $past(req.wr && req.addr == 4'h2 &&
      req.wdata[1] && !cfg.line_control[7]);
  endproperty
  a_rxrst: assert property (p_rxrst)
    else $error("stray rx fifo reset");
  property p_txrst;
    tx_fifo_reset |-> $past(req.wr && req.addr == 4'h2 &&
      req.wdata[2] && !cfg.line_control[7]);
  endproperty
  a_txrst: assert property (p_txrst)
    else $error("stray tx fifo reset");
  property p_lcr;
    req.wr && req.addr == 4'h3 |=> cfg.line_control == $past(req.wdata);
  endproperty
  a_lcr: assert property (p_lcr)
    else $error("line control not written");
  property p_rsvd;
    req.rd && req.addr == 4'hD |=> rd_data == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved read not zero");
  property p_lsr;
    req.rd && req.addr == 4'h5 && cfg.line_control != 8'hBF |=>
      rd_data[7] == $past(rx_stat.global_err) &&
      rd_data[4:1] == $past({rx_stat.brk, rx_stat.framing,
      rx_stat.parity, rx_stat.overrun});
  endproperty
  a_lsr: assert property (p_lsr)
    else $error("line status bits wrong");
  property p_mask;
    cfg.char_mask == (cfg.line_control[1] ?
      (cfg.line_control[0] ? 8'hFF : 8'h7F) :
      (cfg.line_control[0] ? 8'h3F : 8'h1F));
  endproperty
  a_mask: assert property (p_mask)
    else $error("char mask wrong");
  property p_lock;
    !cfg.enhanced[4] |-> (cfg.int_enable & 8'hF0) == 8'h00 &&
      (cfg.modem_control & 8'hE0) == 8'h00 &&
      (cfg.fifo_control & 8'h30) == 8'h00;
  endproperty
  a_lock: assert property (p_lock)
    else $error("enhanced bits visible while locked");
endmodule // urmd_decoder_asserts
bind urmd_decoder urmd_decoder_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .req(req), .rd_data(rd_data),
  .rx_stat(rx_stat), .tx_push(tx_push), .tx_data(tx_data),
  .rx_pop(rx_pop), .rx_fifo_reset(rx_fifo_reset),
  .tx_fifo_reset(tx_fifo_reset), .cfg(cfg));
`default_nettype wire

// file: tb/urmd_core_model.sv
// urmd_core_model: uart core behind the decoder.
// assumes the bench commands receive and transmit events.
`timescale 1ns/1ns
`default_nettype none
module urmd_core_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic rx_go,
  input wire logic tx_go,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic [7:0] tx_data,
  output logic rx_push,
  output logic tx_pop,
  output logic [7:0] rx_data,
  output logic [7:0] last_tx
);
  // events pass straight through from the bench command
  assign rx_push = rx_go;
  assign tx_pop = tx_go;
  // head byte steps on every pop so a lost pop shows in data
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data <= 8'hA0;
      last_tx <= 8'h00;
    end else begin
      if (rx_pop) rx_data <= rx_data + 8'h01;
      if (tx_push) last_tx <= tx_data;
    end
  end
endmodule // urmd_core_model
`default_nettype wire

// file: tb/tb_top.sv
// tb_top: directed register tests of the decoder.
// assumes the core model stands at the core side.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  urmd_pkg::urmd_req_s req = '0;
  urmd_pkg::urmd_rx_stat_s rx_stat = '0;
  urmd_pkg::urmd_cfg_s cfg;
  logic [5:0] int_source = 6'h3F;
  logic [3:0] modem_in = 4'h0;
  logic rx_go = 1'b0, tx_go = 1'b0;
  logic [7:0] rd_data, rx_data, tx_data, last_tx;
  logic rx_push, tx_pop, tx_push, rx_pop, rxr, txr, halt, res;
  int errors = 0, check_count = 0, cyc = 0, halt_n = 0, res_n = 0;
  always #2 mclk = ~mclk;
  urmd_decoder u_dut (.mclk(mclk), .arst_n(arst_n), .req(req),
    .rd_data(rd_data), .rx_data(rx_data), .rx_push(rx_push),
    .tx_pop(tx_pop), .rx_stat(rx_stat), .int_source(int_source),
    .modem_in(modem_in), .tx_push(tx_push), .tx_data(tx_data),
    .rx_pop(rx_pop), .rx_fifo_reset(rxr), .tx_fifo_reset(txr),
    .send_halt(halt), .send_resume(res), .cfg(cfg));
  urmd_core_model u_core (.mclk(mclk), .arst_n(arst_n), .rx_go(rx_go),
    .tx_go(tx_go), .rx_pop(rx_pop), .tx_push(tx_push),
    .tx_data(tx_data), .rx_push(rx_push), .tx_pop(tx_pop),
    .rx_data(rx_data), .last_tx(last_tx));
  // pulse counters and a hang guard
  always @(posedge mclk) begin
    cyc++;
    if (halt) halt_n++;
    if (res) res_n++;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one strobe cycle, then idle so the strobe never re-asserts in place
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk) req = '{1'b1, 1'b0, a, d};
    @(negedge mclk) req = '0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(negedge mclk) req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk) req = '0;
    chk(rd_data, e);
  endtask
  task automatic pulse(input bit rx, input int n);
    repeat (n) @(negedge mclk) if (rx) rx_go = 1'b1; else tx_go = 1'b1;
    @(negedge mclk) {rx_go, tx_go} = 2'b00;
  endtask
  task automatic t_data();
    wr(4'h3, 8'h03);
    wr(4'h0, 8'h55);
    rdc(4'h8, 8'h01);
    chk(last_tx, 8'h55);
    wr(4'h8, 8'h3C);
    rdc(4'h8, 8'h01);
    pulse(0, 1);
    rdc(4'h8, 8'h00);
    rdc(4'h0, 8'hA0);
    pulse(1, 2);
    rdc(4'h9, 8'h02);
    rdc(4'h0, 8'hA0);
    rdc(4'h9, 8'h01);
  endtask
  task automatic t_div();
    wr(4'h3, 8'h83);
    wr(4'h0, 8'h12);
    wr(4'h1, 8'h34);
    rdc(4'h0, 8'h12);
    rdc(4'h1, 8'h34);
    chk(cfg.divisor[15:8], 8'h34);
    wr(4'h2, 8'h2A);
    rdc(4'h2, 8'h00);
    rdc(4'h3, 8'h83);
    wr(4'h3, 8'hBF);
    wr(4'h2, 8'h10);
    rdc(4'h2, 8'h10);
    rdc(4'h0, 8'h00);
    for (int i = 4; i < 8; i++) begin
      wr(4'(i), 8'(8'hC0 + i));
      rdc(4'(i), 8'(8'hC0 + i));
    end
    wr(4'h3, 8'h83);
    wr(4'h2, 8'h2A);
    rdc(4'h2, 8'h2A);
  endtask
  task automatic t_enh();
    wr(4'h3, 8'h03);
    wr(4'h1, 8'hFF);
    rdc(4'h1, 8'hFF);
    wr(4'h4, 8'hFF);
    rdc(4'h4, 8'hFF);
    wr(4'h2, 8'h07);
    rdc(4'h2, 8'hFF);
    rdc(4'h9, 8'h00);
    wr(4'h3, 8'hBF);
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h03);
    rdc(4'h1, 8'h0F);
    rdc(4'h4, 8'h1F);
    rdc(4'h2, 8'hCF);
  endtask
  task automatic t_status();
    rx_stat = '1;
    rdc(4'h5, 8'hFE);
    wr(4'h5, 8'h00);
    rdc(4'h5, 8'hFE);
    modem_in = 4'h5;
    rdc(4'h6, 8'h55);
    rdc(4'h6, 8'h50);
    wr(4'hD, 8'hFF);
    rdc(4'hD, 8'h00);
    wr(4'h7, 8'h5A);
    rdc(4'h7, 8'h5A);
    for (int a = 10; a < 16; a++) if (a != 13) begin
      wr(4'(a), 8'(8'h30 + a));
      rdc(4'(a), 8'(8'h30 + a));
    end
  endtask
  task automatic t_flow();
    wr(4'h3, 8'hBF);
    wr(4'h2, 8'h10);
    wr(4'h3, 8'h03);
    wr(4'h4, 8'h04);
    wr(4'h6, 8'h01);
    rdc(4'h6, 8'h01);
    wr(4'h7, 8'h21);
    rdc(4'h7, 8'h21);
    wr(4'h3, 8'hBF);
    wr(4'h2, 8'h11);
    wr(4'h3, 8'h03);
    pulse(1, 4);
    repeat (3) @(negedge mclk);
    chk(8'(halt_n), 8'h01);
    chk(8'(res_n), 8'h00);
    for (int i = 1; i < 5; i++) rdc(4'h0, 8'(8'hA0 + i));
    repeat (3) @(negedge mclk);
    chk(8'(res_n), 8'h01);
  endtask
  initial begin
    repeat (6) @(negedge mclk);
    arst_n = 1'b1;
    t_data();
    t_div();
    t_enh();
    t_status();
    t_flow();
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
